// [common/bwu_pkg.sv]
package bwu_pkg;

  // register numbers on the register port
  localparam logic [7:0] TRIG_TYPE_OFS   = 8'h15;
  localparam logic [7:0] TRIG_DATA_OFS   = 8'h16;
  localparam logic [7:0] HOLD_OFS        = 8'h18;
  localparam logic [7:0] SCRATCH_OFS     = 8'h20;
  localparam logic [7:0] IB_ADDR_OFS     = 8'h30;
  localparam logic [7:0] IB_CTRL_OFS     = 8'h40;
  localparam logic [7:0] DW_FIRST_OFS    = 8'h50;
  localparam logic [7:0] DW_SECOND_OFS   = 8'h60;
  localparam logic [7:0] DW_CTRL_OFS     = 8'h70;
  localparam logic [7:0] RW_MASK_OFS     = 8'h80;
  localparam logic [7:0] RW_VALUE_OFS    = 8'h90;
  localparam logic [7:0] RW_CTRL_OFS     = 8'h9c;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'ha0;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'ha1;

  // control register fields
  localparam int         CTRL_EN_BIT     = 0;
  localparam int         CTRL_SEL_BIT    = 1;
  localparam int         CTRL_LOAD_BIT   = 2;
  localparam int         CTRL_THR_LSB    = 16;
  localparam logic [31:0] IB_CTRL_WMASK  = 32'h00ff_0003;
  localparam logic [31:0] DW_CTRL_WMASK  = 32'h00ff_0007;
  localparam logic [31:0] RW_CTRL_WMASK  = 32'h00ff_0003;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // trigger type register fields
  localparam int          TYPE_NUM_LSB   = 16;
  localparam int          TYPE_THR_LSB   = 8;
  localparam logic [31:0] TYPE_WMASK     = 32'h0003_ff07;
  localparam logic [2:0]  CAUSE_IBREAK   = 3'h3;
  localparam logic [2:0]  CAUSE_DWATCH   = 3'h4;
  localparam logic [2:0]  CAUSE_RWATCH   = 3'h5;

  // sticky event bits in status and mask
  localparam int          EV_IB_BIT      = 0;
  localparam int          EV_DW_BIT      = 1;
  localparam int          EV_RW_BIT      = 2;
  localparam int          EV_W           = 3;

  localparam int          NUM_UNITS      = 4;
  localparam int          NUM_THREADS    = 8;
  localparam int          SCRATCH_WORDS  = 8;

endpackage : bwu_pkg

// [common/bwu_scratch_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface bwu_scratch_if;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [31:0] wr_data;
  logic [2:0]  rd_addr_a;
  logic [31:0] rd_data_a;
  logic [2:0]  rd_addr_b;
  logic [31:0] rd_data_b;

  modport ctl (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
               input  rd_data_a, rd_data_b);
  modport mem (input  wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
               output rd_data_a, rd_data_b);
endinterface : bwu_scratch_if

`default_nettype wire

// [rtl/bwu_scratch_mem.sv]
`timescale 1ns/10ps
`default_nettype none

module bwu_scratch_mem
(
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // access
  bwu_scratch_if.mem port
);

  typedef struct packed
  {
    logic [bwu_pkg::SCRATCH_WORDS-1:0][31:0] word;
    logic [31:0]                             rd_a;
    logic [31:0]                             rd_b;
  } bwu_mem_state_t;

  bwu_mem_state_t q;
  bwu_mem_state_t d;

  always_comb
  begin
    d      = q;
    // reads see the old word on a same-cycle write
    d.rd_a = q.word[port.rd_addr_a];
    d.rd_b = q.word[port.rd_addr_b];
    if (port.wr_en)
    begin
      d.word[port.wr_addr] = port.wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign port.rd_data_a = q.rd_a;
  assign port.rd_data_b = q.rd_b;

endmodule : bwu_scratch_mem

`default_nettype wire

// [rtl/bwu_trigger_unit.sv]
// Overview of operation
// [RULE1] data watch hit loads trigger data with the access effective address
// [RULE2] resource watch hit loads trigger data with the resource identifier
// [RULE3] 8-bit hold vector stops marked threads while outside debug mode
// [RULE4] eight scratch words, shared with the tile configuration port
// [RULE5] four instruction breakpoints, each with own 32-bit address register
// [RULE6] breakpoint hits on program counter match when enabled for that thread
// [RULE7] compare-mode bit: 0 fires on equal, 1 fires on different
// [RULE8] every control register has a per-thread enable mask in bits 23:16
// [RULE9] bit 0 is the unit master enable, reset to zero
// [RULE10] four data watchpoints with first and second address registers
// [RULE11] load-enable bit lets loads trigger a data watchpoint
// [RULE12] data select bit: 0 needs A and B, 1 needs A or B
// [RULE13] four resource watchpoints with mask and value registers
// [RULE14] resource select bit: 0 fires on condition A, 1 on condition B
// [RULE15] simultaneous triggers record the lowest-numbered unit
// [RULE16] cause codes: instruction 3, data 4, resource 5
// [RULE17] data A is address at or above first, B at or below second
// [RULE18] resource A is masked id equal masked value, B is differing
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module bwu_trigger_unit
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // tile configuration port to scratch words
  input  wire logic [2:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic        cfg_wr,
  output logic      [31:0] cfg_rdata,
  // instruction fetch observation
  input  wire logic        pc_valid,
  input  wire logic [31:0] pc,
  input  wire logic [2:0]  pc_thread,
  // memory access observation
  input  wire logic        mem_valid,
  input  wire logic        mem_load,
  input  wire logic [31:0] mem_addr,
  input  wire logic [2:0]  mem_thread,
  // resource access observation
  input  wire logic        res_valid,
  input  wire logic [31:0] res_id,
  input  wire logic [2:0]  res_thread,
  // core status and debug outputs
  input  wire logic        debug_mode,
  output logic             debug_irq_req,
  output logic      [7:0]  thread_stall,
  output logic             irq
);

  typedef struct packed
  {
    logic [3:0][31:0]          ib_addr;
    logic [3:0][31:0]          ib_ctrl;
    logic [3:0][31:0]          dw_first;
    logic [3:0][31:0]          dw_second;
    logic [3:0][31:0]          dw_ctrl;
    logic [3:0][31:0]          rw_mask;
    logic [3:0][31:0]          rw_value;
    logic [3:0][31:0]          rw_ctrl;
    logic [31:0]               trig_type;
    logic [31:0]               trig_data;
    logic [7:0]                hold;
    logic [bwu_pkg::EV_W-1:0]  status;
    logic [bwu_pkg::EV_W-1:0]  mask;
    logic [31:0]               rdata;
    logic                      rd_mem;
    logic                      req;
    logic [7:0]                stall;
  } bwu_state_t;

  bwu_state_t q;
  bwu_state_t d;

  bwu_scratch_if scr ();

  bwu_scratch_mem u_scratch
  (
    .clk  (clk),
    .rst  (rst),
    .port (scr.mem)
  );

  // unit may fire for this thread only when enabled
  function automatic logic unit_armed(input logic [31:0] ctrl, input logic [2:0] thr);
    logic [7:0] thr_mask;
    thr_mask = ctrl[bwu_pkg::CTRL_THR_LSB +: 8];
    return ctrl[bwu_pkg::CTRL_EN_BIT] && thr_mask[thr]; // [RULE8] [RULE9]
  endfunction : unit_armed

  // lowest set bit wins
  function automatic logic [1:0] lowest(input logic [3:0] hits);
    logic [1:0] n;
    n = 2'h0;
    for (int i = bwu_pkg::NUM_UNITS - 1; i >= 0; i--)
    begin
      if (hits[i])
      begin
        n = 2'(i);
      end
    end
    return n; // [RULE15]
  endfunction : lowest

  // group of four consecutive register numbers
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction : in_group

  function automatic logic [31:0] make_type(input logic [2:0] cause, input logic [1:0] num,
                                            input logic [2:0] thr);
    logic [31:0] t;
    t                                  = 32'h0000_0000;
    t[2:0]                             = cause;
    t[bwu_pkg::TYPE_THR_LSB +: 8]      = {5'h00, thr};
    t[bwu_pkg::TYPE_NUM_LSB +: 2]      = num;
    return t;
  endfunction : make_type

  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  always_comb
  begin
    logic cond_a;
    logic cond_b;
    logic match;
    cond_a = 1'b0;
    cond_b = 1'b0;
    match  = 1'b0;
    ib_hit = 4'h0;
    dw_hit = 4'h0;
    rw_hit = 4'h0;
    for (int i = 0; i < bwu_pkg::NUM_UNITS; i++)
    begin
      // equality flipped by compare mode
      ib_hit[i] = pc_valid && unit_armed(q.ib_ctrl[i], pc_thread) // [RULE5] [RULE6]
                  && ((pc == q.ib_addr[i]) ^ q.ib_ctrl[i][bwu_pkg::CTRL_SEL_BIT]); // [RULE7]
      cond_a = mem_addr >= q.dw_first[i]; // [RULE17]
      cond_b = mem_addr <= q.dw_second[i]; // [RULE17]
      // stores always qualify; loads only when allowed
      dw_hit[i] = mem_valid && unit_armed(q.dw_ctrl[i], mem_thread) // [RULE10]
                  && (!mem_load || q.dw_ctrl[i][bwu_pkg::CTRL_LOAD_BIT]) // [RULE11]
                  && (q.dw_ctrl[i][bwu_pkg::CTRL_SEL_BIT] ? (cond_a || cond_b)
                                                          : (cond_a && cond_b)); // [RULE12]
      match = (res_id & q.rw_mask[i]) == (q.rw_value[i] & q.rw_mask[i]); // [RULE13] [RULE18]
      rw_hit[i] = res_valid && unit_armed(q.rw_ctrl[i], res_thread)
                  && (q.rw_ctrl[i][bwu_pkg::CTRL_SEL_BIT] ? !match : match); // [RULE14]
    end
  end

  always_comb
  begin
    logic [1:0] idx;
    idx      = reg_addr[1:0];
    d        = q;
    d.req    = 1'b0;
    d.rd_mem = 1'b0;

    if (reg_wr)
    begin
      if (reg_addr == bwu_pkg::TRIG_TYPE_OFS)
      begin
        d.trig_type = reg_wdata & bwu_pkg::TYPE_WMASK;
      end
      if (reg_addr == bwu_pkg::TRIG_DATA_OFS)
      begin
        d.trig_data = reg_wdata;
      end
      if (reg_addr == bwu_pkg::HOLD_OFS)
      begin
        d.hold = reg_wdata[7:0]; // [RULE3]
      end
      if (in_group(reg_addr, bwu_pkg::IB_ADDR_OFS))
      begin
        d.ib_addr[idx] = reg_wdata;
      end
      if (in_group(reg_addr, bwu_pkg::IB_CTRL_OFS))
      begin
        d.ib_ctrl[idx] = reg_wdata & bwu_pkg::IB_CTRL_WMASK;
      end
      if (in_group(reg_addr, bwu_pkg::DW_FIRST_OFS))
      begin
        d.dw_first[idx] = reg_wdata;
      end
      if (in_group(reg_addr, bwu_pkg::DW_SECOND_OFS))
      begin
        d.dw_second[idx] = reg_wdata;
      end
      if (in_group(reg_addr, bwu_pkg::DW_CTRL_OFS))
      begin
        d.dw_ctrl[idx] = reg_wdata & bwu_pkg::DW_CTRL_WMASK;
      end
      if (in_group(reg_addr, bwu_pkg::RW_MASK_OFS))
      begin
        d.rw_mask[idx] = reg_wdata;
      end
      if (in_group(reg_addr, bwu_pkg::RW_VALUE_OFS))
      begin
        d.rw_value[idx] = reg_wdata;
      end
      if (in_group(reg_addr, bwu_pkg::RW_CTRL_OFS))
      begin
        d.rw_ctrl[idx] = reg_wdata & bwu_pkg::RW_CTRL_WMASK;
      end
      if (reg_addr == bwu_pkg::IRQ_STATUS_OFS)
      begin
        d.status = q.status & ~reg_wdata[bwu_pkg::EV_W-1:0];
      end
      if (reg_addr == bwu_pkg::IRQ_MASK_OFS)
      begin
        d.mask = reg_wdata[bwu_pkg::EV_W-1:0];
      end
    end

    // triggers follow the write so a new event beats a same-cycle clear;
    // no triggers while the handler itself runs, to avoid re-entry
    if (!debug_mode)
    begin
      if (|ib_hit)
      begin
        d.trig_type = make_type(bwu_pkg::CAUSE_IBREAK, lowest(ib_hit), pc_thread); // [RULE16]
        d.status[bwu_pkg::EV_IB_BIT] = 1'b1;
        d.req = 1'b1;
      end
      else if (|dw_hit)
      begin
        d.trig_type = make_type(bwu_pkg::CAUSE_DWATCH, lowest(dw_hit), mem_thread); // [RULE16]
        d.trig_data = mem_addr; // [RULE1]
        d.status[bwu_pkg::EV_DW_BIT] = 1'b1;
        d.req = 1'b1;
      end
      else if (|rw_hit)
      begin
        d.trig_type = make_type(bwu_pkg::CAUSE_RWATCH, lowest(rw_hit), res_thread); // [RULE16]
        d.trig_data = res_id; // [RULE2]
        d.status[bwu_pkg::EV_RW_BIT] = 1'b1;
        d.req = 1'b1;
      end
    end

    // threads held only while the debug handler is not running
    d.stall = debug_mode ? 8'h00 : d.hold; // [RULE3]

    d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      if (reg_addr[7:3] == bwu_pkg::SCRATCH_OFS[7:3])
      begin
        d.rd_mem = 1'b1; // [RULE4]
      end
      else if (reg_addr == bwu_pkg::TRIG_TYPE_OFS)
      begin
        d.rdata = q.trig_type;
      end
      else if (reg_addr == bwu_pkg::TRIG_DATA_OFS)
      begin
        d.rdata = q.trig_data;
      end
      else if (reg_addr == bwu_pkg::HOLD_OFS)
      begin
        d.rdata = {24'h00_0000, q.hold};
      end
      else if (in_group(reg_addr, bwu_pkg::IB_ADDR_OFS))
      begin
        d.rdata = q.ib_addr[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::IB_CTRL_OFS))
      begin
        d.rdata = q.ib_ctrl[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::DW_FIRST_OFS))
      begin
        d.rdata = q.dw_first[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::DW_SECOND_OFS))
      begin
        d.rdata = q.dw_second[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::DW_CTRL_OFS))
      begin
        d.rdata = q.dw_ctrl[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::RW_MASK_OFS))
      begin
        d.rdata = q.rw_mask[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::RW_VALUE_OFS))
      begin
        d.rdata = q.rw_value[idx];
      end
      else if (in_group(reg_addr, bwu_pkg::RW_CTRL_OFS))
      begin
        d.rdata = q.rw_ctrl[idx];
      end
      else if (reg_addr == bwu_pkg::IRQ_STATUS_OFS)
      begin
        d.rdata = {29'h0000_0000, q.status};
      end
      else if (reg_addr == bwu_pkg::IRQ_MASK_OFS)
      begin
        d.rdata = {29'h0000_0000, q.mask};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0; // [RULE9]
    end
    else
    begin
      q <= d;
    end
  end

  // scratch: register port has priority on a same-cycle write
  assign scr.wr_en     = (reg_wr && reg_addr[7:3] == bwu_pkg::SCRATCH_OFS[7:3]) || cfg_wr; // [RULE4]
  assign scr.wr_addr   = (reg_wr && reg_addr[7:3] == bwu_pkg::SCRATCH_OFS[7:3])
                         ? reg_addr[2:0] : cfg_addr;
  assign scr.wr_data   = (reg_wr && reg_addr[7:3] == bwu_pkg::SCRATCH_OFS[7:3])
                         ? reg_wdata : cfg_wdata;
  assign scr.rd_addr_a = reg_addr[2:0];
  assign scr.rd_addr_b = cfg_addr;

  assign reg_rdata     = q.rd_mem ? scr.rd_data_a : q.rdata;
  assign cfg_rdata     = scr.rd_data_b;
  assign debug_irq_req = q.req;
  assign thread_stall  = q.stall;
  assign irq           = |(q.status & q.mask);

endmodule : bwu_trigger_unit

`default_nettype wire

// [test/bwu_trigger_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

module bwu_trigger_monitor
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // scratch port
  input wire logic [2:0]  cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic        cfg_wr,
  input wire logic [31:0] cfg_rdata,
  // observation and debug
  input wire logic        pc_valid,
  input wire logic        mem_valid,
  input wire logic        res_valid,
  input wire logic        debug_mode,
  input wire logic        debug_irq_req,
  input wire logic [7:0]  thread_stall,
  input wire logic        irq
);
  default clocking mcb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence hold_wr_s;
    reg_wr && reg_addr == bwu_pkg::HOLD_OFS;
  endsequence
  sequence hold_run_s;
    !debug_mode && !(reg_wr && reg_addr == bwu_pkg::HOLD_OFS);
  endsequence
  // cfg writes are kept out so the read-back cannot be disturbed
  sequence scr_wr_s;
    reg_wr && reg_addr[7:3] == bwu_pkg::SCRATCH_OFS[7:3] && !cfg_wr;
  endsequence
  sequence same_rd_s;
    reg_rd && !cfg_wr && reg_addr == $past(reg_addr);
  endsequence
  sequence cfg_wr_s;
    cfg_wr && !reg_wr;
  endsequence
  sequence cfg_idle_s;
    !cfg_wr && !reg_wr && $stable(cfg_addr);
  endsequence

  a_hold_stall_out: assert property (
    hold_wr_s ##1 hold_run_s |=> thread_stall == $past(reg_wdata[7:0], 2))
    else $error("stall vector differs from hold value");
  a_stall_in_debug: assert property (
    $past(debug_mode) |-> thread_stall == 8'h00)
    else $error("threads stalled during debug");
  a_req_not_debug: assert property (
    debug_irq_req |-> !$past(debug_mode))
    else $error("trigger taken in debug mode");
  a_req_has_cause: assert property (
    debug_irq_req |-> $past(pc_valid || mem_valid || res_valid))
    else $error("trigger without observed access");
  a_scratch_reg_back: assert property (
    scr_wr_s ##1 same_rd_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("scratch read-back differs");
  a_scratch_cfg_back: assert property (
    cfg_wr_s ##1 cfg_idle_s |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("cfg scratch read-back differs");
  a_ctrl_reserved_zero: assert property (
    reg_wr && reg_addr[7:2] == bwu_pkg::IB_CTRL_OFS[7:2] ##1 same_rd_s
    |=> reg_rdata == ($past(reg_wdata, 2) & bwu_pkg::IB_CTRL_WMASK))
    else $error("control reserved bits not zero");
  a_mask_off_irq: assert property (
    reg_wr && reg_addr == bwu_pkg::IRQ_MASK_OFS && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all masked");
endmodule : bwu_trigger_monitor

bind bwu_trigger_unit bwu_trigger_monitor u_bwu_trigger_monitor (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rdata, .pc_valid, .mem_valid,
  .res_valid, .debug_mode, .debug_irq_req, .thread_stall, .irq
);

`default_nettype wire

// [test/bwu_core_model.sv]
`timescale 1ns/10ps
`default_nettype none

module bwu_core_model
#(
  parameter int HANDLER_CYCLES = 6
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // debug handshake
  input  wire logic debug_irq_req,
  output logic      debug_mode
);
  // fixed handler length; the bench waits on the level, not on the count
  logic [7:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= 8'h00;
    else if (debug_irq_req)
      cnt_q <= 8'(HANDLER_CYCLES);
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  assign debug_mode = cnt_q != 8'h00;
endmodule : bwu_core_model

`default_nettype wire

// [test/tb_breakpoint_watchpoint_unit.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_breakpoint_watchpoint_unit;
  typedef struct packed {logic [1:0] k; logic [31:0] v; logic [3:0] lc; logic f;} bwu_case_t;
  logic        clk = 1'b0, rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, cfg_wdata = 32'h0, pc = 32'h0, mem_addr = 32'h0;
  logic [31:0] res_id = 32'h0, reg_rdata, cfg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, cfg_wr = 1'b0, mem_load = 1'b0;
  logic        pc_valid = 1'b0, mem_valid = 1'b0, res_valid = 1'b0;
  logic [2:0]  cfg_addr = 3'h0, pc_thread = 3'h0, mem_thread = 3'h0, res_thread = 3'h0;
  logic        debug_mode, debug_irq_req, irq;
  logic [7:0]  thread_stall;
  logic [31:0] exp_rd[$];
  logic        exp_req[$];
  logic        rd_seen = 1'b0, obs_seen = 1'b0;
  int          err_total = 0, checks = 0;

  always #5 clk = ~clk;

  bwu_trigger_unit u_bwu_trigger_unit (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rdata, .pc_valid, .pc, .pc_thread,
    .mem_valid, .mem_load, .mem_addr, .mem_thread, .res_valid, .res_id, .res_thread,
    .debug_mode, .debug_irq_req, .thread_stall, .irq);
  bwu_core_model #(.HANDLER_CYCLES(6)) u_bwu_core_model (.clk, .rst, .debug_irq_req,
    .debug_mode);

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // write, optionally read the same register back in the very next cycle
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic rb,
                     input logic [31:0] e);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    if (rb)
    begin
      reg_rd <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
    end
    @(posedge clk);
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
  endtask : rd

  // one observed access; w waits for the handler to end first
  task automatic obs(input int k, input logic [31:0] v, input logic ld, input logic [2:0] t,
                     input logic f, input logic w);
    int n;
    n = 0;
    while (w && debug_mode !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    case (k)
      0: begin pc_valid <= 1'b1; pc <= v; pc_thread <= t; end
      1: begin mem_valid <= 1'b1; mem_addr <= v; mem_load <= ld; mem_thread <= t; end
      default: begin res_valid <= 1'b1; res_id <= v; res_thread <= t; end
    endcase
    exp_req.push_back(f);
    @(posedge clk);
    pc_valid  <= 1'b0;
    mem_valid <= 1'b0;
    res_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : obs

  always @(posedge clk)
  begin
    if (rd_seen && exp_rd.size() > 0)
      cmp("reg_rdata", exp_rd.pop_front(), reg_rdata);
    if (obs_seen && exp_req.size() > 0)
      cmp("debug_irq_req", {31'h0, exp_req.pop_front()}, {31'h0, debug_irq_req});
    rd_seen  <= reg_rd;
    obs_seen <= pc_valid | mem_valid | res_valid;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial
  begin
    logic [7:0]  cb [3];
    logic [31:0] cm [3];
    logic [31:0] a, d;
    logic [2:0]  t;
    logic [1:0]  u;
    bwu_case_t   tab [12];
    bwu_case_t   c;
    cb = '{bwu_pkg::IB_CTRL_OFS, bwu_pkg::DW_CTRL_OFS, bwu_pkg::RW_CTRL_OFS};
    cm = '{bwu_pkg::IB_CTRL_WMASK, bwu_pkg::DW_CTRL_WMASK, bwu_pkg::RW_CTRL_WMASK};
    tab = '{{2'd1, 32'h1800, 4'h1, 1'b1}, {2'd1, 32'h1000, 4'h1, 1'b1},
            {2'd1, 32'h2000, 4'h1, 1'b1}, {2'd1, 32'h2001, 4'h1, 1'b0},
            {2'd1, 32'h0fff, 4'h1, 1'b0}, {2'd1, 32'h3000, 4'h3, 1'b1},
            {2'd1, 32'h1800, 4'h9, 1'b0}, {2'd1, 32'h1800, 4'hd, 1'b1},
            {2'd2, 32'h12ab, 4'h1, 1'b1}, {2'd2, 32'h13ab, 4'h1, 1'b0},
            {2'd2, 32'h13ab, 4'h3, 1'b1}, {2'd2, 32'h12cd, 4'h3, 1'b0}};
    void'($urandom(32'hfa88));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, reserved bits, and a disabled unit staying quiet
    for (int b = 0; b < 3; b++)
      for (int i = 0; i < 4; i++)
      begin
        rd(cb[b] + 8'(i), bwu_pkg::CTRL_RESET);
        acc(cb[b] + 8'(i), 32'hffff_fffe, 1'b1, 32'hffff_fffe & cm[b]);
        if (b == 0)
          obs(0, $urandom(), 1'b0, 3'(i), 1'b0, 1'b1);
        acc(cb[b] + 8'(i), 32'h0, 1'b0, 32'h0);
      end
    rd(8'hff, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom();
      acc(bwu_pkg::SCRATCH_OFS + 8'(i), d, 1'b1, d);
    end
    cfg_addr  <= 3'h5;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("cfg_rdata", d, cfg_rdata);
    rd(bwu_pkg::SCRATCH_OFS + 8'h05, d);
    for (int i = 0; i < 4; i++)
    begin
      a = $urandom();
      t = 3'($urandom_range(7));
      acc(bwu_pkg::IB_ADDR_OFS + 8'(i), a, 1'b1, a);
      acc(bwu_pkg::IB_CTRL_OFS + 8'(i), {8'h0, 8'h1 << t, 16'h1}, 1'b0, 32'h0);
      obs(0, a, 1'b0, t, 1'b1, 1'b1);
      rd(bwu_pkg::TRIG_TYPE_OFS, {14'h0, 2'(i), 5'h0, t, 5'h0, bwu_pkg::CAUSE_IBREAK});
      obs(0, a, 1'b0, t + 3'h1, 1'b0, 1'b1);
      obs(0, a ^ 32'h4, 1'b0, t, 1'b0, 1'b1);
      acc(bwu_pkg::IB_CTRL_OFS + 8'(i), {8'h0, 8'h1 << t, 16'h3}, 1'b0, 32'h0);
      obs(0, a, 1'b0, t, 1'b0, 1'b1);
      obs(0, a ^ 32'h4, 1'b0, t, 1'b1, 1'b1);
      acc(bwu_pkg::IB_CTRL_OFS + 8'(i), 32'h0, 1'b0, 32'h0);
    end
    acc(bwu_pkg::IB_ADDR_OFS, a, 1'b0, 32'h0);
    acc(bwu_pkg::IB_CTRL_OFS, 32'h00ff_0001, 1'b0, 32'h0);
    acc(bwu_pkg::IB_CTRL_OFS + 8'h03, 32'h00ff_0001, 1'b0, 32'h0);
    obs(0, a, 1'b0, 3'h2, 1'b1, 1'b1);
    rd(bwu_pkg::TRIG_TYPE_OFS, {24'h2, 5'h0, bwu_pkg::CAUSE_IBREAK});
    obs(0, a, 1'b0, 3'h2, 1'b0, 1'b0);
    acc(bwu_pkg::DW_FIRST_OFS + 8'h01, 32'h1000, 1'b1, 32'h1000);
    acc(bwu_pkg::DW_SECOND_OFS + 8'h01, 32'h2000, 1'b1, 32'h2000);
    acc(bwu_pkg::RW_MASK_OFS + 8'h03, 32'hff00, 1'b1, 32'hff00);
    acc(bwu_pkg::RW_VALUE_OFS + 8'h03, 32'h1200, 1'b1, 32'h1200);
    t = 3'($urandom_range(7));
    foreach (tab[i])
    begin
      c = tab[i];
      u = (c.k == 2'd1) ? 2'd1 : 2'd3;
      acc(((c.k == 2'd1) ? bwu_pkg::DW_CTRL_OFS : bwu_pkg::RW_CTRL_OFS) + 8'(u),
          {8'h0, 8'h1 << t, 13'h0, c.lc[2:0]}, 1'b0, 32'h0);
      obs(int'(c.k), c.v, c.lc[3], t, c.f, 1'b1);
      if (c.f)
      begin
        rd(bwu_pkg::TRIG_DATA_OFS, c.v);
        rd(bwu_pkg::TRIG_TYPE_OFS, {14'h0, u, 5'h0, t, 5'h0,
           (c.k == 2'd1) ? bwu_pkg::CAUSE_DWATCH : bwu_pkg::CAUSE_RWATCH});
      end
    end
    // events stay sticky until a one is written back
    cmp("irq", 32'h0, {31'h0, irq});
    acc(bwu_pkg::IRQ_MASK_OFS, 32'h7, 1'b1, 32'h7);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(bwu_pkg::IRQ_STATUS_OFS, 32'h7);
    acc(bwu_pkg::IRQ_STATUS_OFS, 32'h1, 1'b1, 32'h6);
    acc(bwu_pkg::IRQ_MASK_OFS, 32'h0, 1'b0, 32'h0);
    acc(bwu_pkg::IRQ_STATUS_OFS, 32'h6, 1'b1, 32'h0);
    d = $urandom();
    acc(bwu_pkg::HOLD_OFS, d, 1'b1, {24'h0, d[7:0]});
    cmp("thread_stall", {24'h0, d[7:0]}, {24'h0, thread_stall});
    obs(0, a, 1'b0, 3'h1, 1'b1, 1'b1);
    @(posedge clk);
    cmp("thread_stall", 32'h0, {24'h0, thread_stall});
    repeat (10) @(posedge clk);
    cmp("thread_stall", {24'h0, d[7:0]}, {24'h0, thread_stall});
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule : tb_breakpoint_watchpoint_unit

`default_nettype wire
